// ==== hdl/sim_cfg.svh ====
// register map, field positions and reset values of the irq/modulator block
`ifndef SIM_CFG_SVH
`define SIM_CFG_SVH
`define SIM_ADDR_INT_CTRL   8'h89
`define SIM_ADDR_LOW_HI     8'h8a
`define SIM_ADDR_LOW_LO     8'h8b
`define SIM_ADDR_HIGH_HI    8'h8c
`define SIM_ADDR_HIGH_LO    8'h8d
`define SIM_ADDR_FLAGS      8'h8e
`define SIM_ADDR_MOD_TIMING 8'h8f
`define SIM_ADDR_RSVD_IR    8'h90
`define SIM_MOD_TIMING_RST  8'h01
`define SIM_INT_CTRL_RST    8'h00
`define SIM_FLG_OVER        0
`define SIM_FLG_UNDER       1
`define SIM_FLG_ALS         2
`define SIM_FLG_PROX        3
`define SIM_CTL_SRC_SEL     0
`define SIM_CTL_LIM_EN      1
`define SIM_CTL_ALS_EN      2
`define SIM_CTL_PROX_EN     3
`define SIM_CTL_PERS_LSB    5
`define SIM_FLAG_MASK       8'h0f
`define SIM_PHASE_W         8
`endif

// ==== hdl/sim_pkg.sv ====
// types of the irq status and modulator timing block
package sim_pkg;
	typedef struct packed {
		logic [2:0] mod_delay;
		logic [1:0] prox_freq;
		logic [2:0] dead_time;
	} sim_mod_timing_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} sim_reg_wr_t;

	typedef struct packed {
		logic        prox_ready;
		logic        als_ready;
		logic [15:0] prox_value;
		logic [15:0] als_value;
	} sim_meas_t;
endpackage : sim_pkg

// ==== hdl/sim_irq_mod.sv ====
// irq status flags, limit check and emitter modulation timing
//
// Overview of operation
// - event_flags at 8Eh report proximity and light ready events.
// - event_flags also report over-limit and under-limit conditions.
// - under_limit_flag sets when selected result drops below low limit.
// - over_limit_flag sets when selected result rises above high limit.
// - flags hold until host writes one; writing zero changes nothing.
// - irq_n output is low while any flag is set.
// - timing register 8Fh: delay 7:5, frequency 4:3, dead time 2:0.
// - delay field shifts evaluation after emitter pulse; resets to 0.
// - delay compensates emitter and photodiode propagation.
// - limit events gated by limit_irq_enable; ready events by own enables.
// - limit_source_select 0 compares proximity, 1 compares ambient light.
// - limit event needs 1,2,4..128 consecutive results beyond limit.
// - limits are 16-bit, high byte at lower address.
`timescale 1ns/10ps
`include "sim_cfg.svh"
module sim_irq_mod #(
	parameter int PHASE_W = `SIM_PHASE_W
) (
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	input  wire sim_pkg::sim_reg_wr_t reg_wr_i,
	input  wire logic [7:0]        rd_addr_i,
	input  wire sim_pkg::sim_meas_t meas_i,
	output logic [7:0]             rd_data_o,
	output logic                   irq_n_o,
	output logic                   emitter_o,
	output logic                   eval_window_o
);
	// register state
	sim_pkg::sim_mod_timing_t timing_q, timing_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [15:0] low_lim_q, low_lim_d;
	logic [15:0] high_lim_q, high_lim_d;
	logic [3:0]  flags_q, flags_d;
	logic [7:0]  over_run_q, over_run_d;
	logic [7:0]  under_run_q, under_run_d;
	logic [7:0]  rd_data_q, rd_data_d;
	logic        irq_n_q, irq_n_d;
	// modulator state
	logic [PHASE_W-1:0] phase_q, phase_d;
	logic [PHASE_W-1:0] half_per;
	logic               emit_q, emit_d;
	logic               win_q, win_d;
	logic               wr_flags;
	logic               sel_ready;
	logic [15:0]        sel_value;
	logic [7:0]         pers_need;
	logic               over_hit, under_hit;
	logic [3:0]         events;

	assign wr_flags = reg_wr_i.wr && reg_wr_i.addr == `SIM_ADDR_FLAGS;

	always_comb begin
		// limit comparison source
		sel_ready = ctrl_q[`SIM_CTL_SRC_SEL] ? meas_i.als_ready
			: meas_i.prox_ready;
		sel_value = ctrl_q[`SIM_CTL_SRC_SEL] ? meas_i.als_value
			: meas_i.prox_value;
		pers_need = 8'h01 << ctrl_q[`SIM_CTL_PERS_LSB +: 3];
		over_run_d  = over_run_q;
		under_run_d = under_run_q;
		over_hit    = 1'b0;
		under_hit   = 1'b0;
		if (sel_ready) begin
			// runs saturate so a long excursion fires only once
			if (sel_value > high_lim_q) begin
				if (over_run_q != 8'hff)
					over_run_d = over_run_q + 8'h01;
				over_hit = (over_run_q + 8'h01) == pers_need;
			end else begin
				over_run_d = 8'h00;
			end
			if (sel_value < low_lim_q) begin
				if (under_run_q != 8'hff)
					under_run_d = under_run_q + 8'h01;
				under_hit = (under_run_q + 8'h01) == pers_need;
			end else begin
				under_run_d = 8'h00;
			end
		end
		events = 4'h0;
		events[`SIM_FLG_OVER]  = over_hit && ctrl_q[`SIM_CTL_LIM_EN];
		events[`SIM_FLG_UNDER] = under_hit && ctrl_q[`SIM_CTL_LIM_EN];
		events[`SIM_FLG_ALS]   = meas_i.als_ready
			&& ctrl_q[`SIM_CTL_ALS_EN];
		events[`SIM_FLG_PROX]  = meas_i.prox_ready
			&& ctrl_q[`SIM_CTL_PROX_EN];
		// set wins over write-one clear
		flags_d = flags_q;
		if (wr_flags)
			flags_d = flags_q & ~reg_wr_i.data[3:0];
		flags_d = flags_d | events;
		irq_n_d = ~|flags_d;
	end

	always_comb begin
		timing_d   = timing_q;
		ctrl_d     = ctrl_q;
		low_lim_d  = low_lim_q;
		high_lim_d = high_lim_q;
		if (reg_wr_i.wr) begin
			unique case (reg_wr_i.addr)
				`SIM_ADDR_MOD_TIMING: timing_d = reg_wr_i.data;
				`SIM_ADDR_INT_CTRL:   ctrl_d = reg_wr_i.data;
				`SIM_ADDR_LOW_HI:     low_lim_d[15:8] = reg_wr_i.data;
				`SIM_ADDR_LOW_LO:     low_lim_d[7:0] = reg_wr_i.data;
				`SIM_ADDR_HIGH_HI:    high_lim_d[15:8] = reg_wr_i.data;
				`SIM_ADDR_HIGH_LO:    high_lim_d[7:0] = reg_wr_i.data;
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (rd_addr_i)
			`SIM_ADDR_INT_CTRL:   rd_data_d = ctrl_q;
			`SIM_ADDR_LOW_HI:     rd_data_d = low_lim_q[15:8];
			`SIM_ADDR_LOW_LO:     rd_data_d = low_lim_q[7:0];
			`SIM_ADDR_HIGH_HI:    rd_data_d = high_lim_q[15:8];
			`SIM_ADDR_HIGH_LO:    rd_data_d = high_lim_q[7:0];
			`SIM_ADDR_FLAGS:      rd_data_d = {4'h0, flags_q};
			`SIM_ADDR_MOD_TIMING: rd_data_d = timing_q;
			// reserved ambient ir level is not modelled, reads zero
			default:              rd_data_d = 8'h00;
		endcase
	end

	// emitter square wave; half period doubles per frequency step
	assign half_per = PHASE_W'(16) << timing_q.prox_freq;

	always_comb begin
		if (phase_q >= half_per - PHASE_W'(1)) begin
			phase_d = '0;
			emit_d  = ~emit_q;
		end else begin
			phase_d = phase_q + PHASE_W'(1);
			emit_d  = emit_q;
		end
		// receive window trails emitter by delay, trimmed by dead time
		win_d = emit_q
			&& phase_q >= PHASE_W'(timing_q.mod_delay)
				+ PHASE_W'(timing_q.dead_time)
			&& phase_q < half_per - PHASE_W'(timing_q.dead_time);
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timing_q    <= `SIM_MOD_TIMING_RST;
			ctrl_q      <= `SIM_INT_CTRL_RST;
			low_lim_q   <= 16'h0000;
			high_lim_q  <= 16'h0000;
			flags_q     <= 4'h0;
			over_run_q  <= 8'h00;
			under_run_q <= 8'h00;
			rd_data_q   <= 8'h00;
			irq_n_q     <= 1'b1;
			phase_q     <= '0;
			emit_q      <= 1'b0;
			win_q       <= 1'b0;
		end else begin
			timing_q    <= timing_d;
			ctrl_q      <= ctrl_d;
			low_lim_q   <= low_lim_d;
			high_lim_q  <= high_lim_d;
			flags_q     <= flags_d;
			over_run_q  <= over_run_d;
			under_run_q <= under_run_d;
			rd_data_q   <= rd_data_d;
			irq_n_q     <= irq_n_d;
			phase_q     <= phase_d;
			emit_q      <= emit_d;
			win_q       <= win_d;
		end
	end

	assign rd_data_o     = rd_data_q;
	assign irq_n_o       = irq_n_q;
	assign emitter_o     = emit_q;
	assign eval_window_o = win_q;
endmodule : sim_irq_mod

// ==== sim/sim_irq_mod_checker.sv ====
// port assertions of the irq/modulator block
`timescale 1ns/10ps
module sim_irq_mod_checker (
	input wire logic                 clock_i,
	input wire logic                 sys_rst_i,
	input wire sim_pkg::sim_reg_wr_t reg_wr_i,
	input wire logic [7:0]           rd_addr_i,
	input wire sim_pkg::sim_meas_t   meas_i,
	input wire logic [7:0]           rd_data_o,
	input wire logic                 irq_n_o,
	input wire logic                 emitter_o,
	input wire logic                 eval_window_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire logic rdy = meas_i.prox_ready | meas_i.als_ready;
	// no ready pulse, so no event can mask the write
	sequence s_w8e(d);
		reg_wr_i.wr && reg_wr_i.addr == 8'h8e && reg_wr_i.data == d && !rdy;
	endsequence
	sequence s_w8f;
		reg_wr_i.wr && reg_wr_i.addr == 8'h8f;
	endsequence
	AST_RSVD: assert property (rd_addr_i == 8'h90 |=> rd_data_o == 8'h00)
		else $error("reserved read not zero");
	AST_TOP: assert property (rd_addr_i == 8'h8e |=> rd_data_o[7:4] == 4'h0)
		else $error("unused flag bits set");
	AST_IRQ: assert property (rd_addr_i == 8'h8e |=> (|rd_data_o) == !$past(irq_n_o))
		else $error("irq differs from flags");
	AST_SET: assert property ($fell(irq_n_o) |-> $past(rdy))
		else $error("irq without event");
	AST_REL: assert property ($rose(irq_n_o) |-> $past(reg_wr_i.wr))
		else $error("irq released without write");
	AST_WIN: assert property (eval_window_o |-> emitter_o)
		else $error("window outside pulse");
	AST_RW: assert property (s_w8f ##1 (rd_addr_i == 8'h8f && !reg_wr_i.wr)
		|=> rd_data_o == $past(reg_wr_i.data, 2)) else $error("timing readback");
	AST_KEEP: assert property (s_w8e(8'h00) |=> $stable(irq_n_o))
		else $error("zero write changed flags");
	AST_CLR: assert property (s_w8e(8'h0f) |=> irq_n_o)
		else $error("irq held after clear");
endmodule : sim_irq_mod_checker
bind sim_irq_mod sim_irq_mod_checker u_chk (.clock_i(clock_i),
	.sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .rd_addr_i(rd_addr_i),
	.meas_i(meas_i), .rd_data_o(rd_data_o), .irq_n_o(irq_n_o),
	.emitter_o(emitter_o), .eval_window_o(eval_window_o));

// ==== sim/sim_host.sv ====
// host model on the register bus
`timescale 1ns/10ps
module sim_host (
	input  wire logic                 clock_i,
	input  wire logic [7:0]           rd_data_i,
	output sim_pkg::sim_reg_wr_t      reg_wr_o,
	output logic [7:0]                rd_addr_o
);
	initial reg_wr_o = '0;
	initial rd_addr_o = 8'h8f;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_o <= '{1'b1, a, d};
		@(posedge clock_i);
		reg_wr_o <= '{1'b0, ~a, ~d};
		// one idle edge so a following write never reassigns in this step
		@(posedge clock_i);
	endtask : wr
	// sampled at the edge, before that edge's update lands
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		rd_addr_o <= a;
		repeat (2) @(posedge clock_i);
		q = rd_data_i;
	endtask : rd
endmodule : sim_host

// ==== sim/tb_sensor_irq_status_and_modulator_timing.sv ====
// self-checking bench of the irq/modulator block
`timescale 1ns/10ps
module tb_sensor_irq_status_and_modulator_timing;
	logic                 clock_i = 1'b0;
	logic                 sys_rst_i = 1'b1;
	sim_pkg::sim_reg_wr_t reg_wr;
	sim_pkg::sim_meas_t   meas = '0;
	logic [7:0]           rd_addr, rd_data, q, d;
	logic [15:0]          v;
	logic                 irq_n, emit, win;
	int                   hi, wn;
	int                   err_count = 0, checks = 0, cyc = 0;
	initial forever #5 clock_i = ~clock_i;
	sim_host h (.clock_i(clock_i), .rd_data_i(rd_data), .reg_wr_o(reg_wr),
		.rd_addr_o(rd_addr));
	sim_irq_mod u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.reg_wr_i(reg_wr), .rd_addr_i(rd_addr), .meas_i(meas),
		.rd_data_o(rd_data), .irq_n_o(irq_n), .emitter_o(emit),
		.eval_window_o(win));
	function automatic logic [7:0] lim(input logic [15:0] x);
		return {6'h0, x < 16'h0100, x > 16'h8000};
	endfunction : lim
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		h.rd(a, q);
		chk(q, e);
	endtask : rc
	task automatic ev(input logic p, a, input logic [15:0] pv, av);
		meas <= '{p, a, pv, av};
		@(posedge clock_i);
		meas <= '{1'b0, 1'b0, ~pv, ~av};
		@(posedge clock_i);
	endtask : ev
	// length of one emitter high half and window cycles inside it
	task automatic emit_run(output int h_cnt, output int w_cnt);
		h_cnt = 0;
		w_cnt = 0;
		while (emit !== 1'b0) @(posedge clock_i);
		while (emit !== 1'b1) @(posedge clock_i);
		while (emit === 1'b1) begin
			h_cnt++;
			w_cnt += int'(win);
			@(posedge clock_i);
		end
	endtask : emit_run
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		void'($urandom(26));
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rc(8'h8f, 8'h01);
		rc(8'h8e, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			d[4:3] = 2'(i);
			h.wr(8'h8f, d);
			rc(8'h8f, d);
		end
		h.wr(8'h8f, 8'h01);
		emit_run(hi, wn);
		chk(8'(hi), 8'h10);
		chk(8'(wn), 8'h0e);
		h.wr(8'h8f, 8'h4a);
		emit_run(hi, wn);
		chk(8'(hi), 8'h20);
		chk(8'(wn), 8'h1a);
		h.wr(8'h8f, 8'h01);
		h.wr(8'h90, 8'hff);
		rc(8'h90, 8'h00);
		$display("test registers done");
		h.wr(8'h89, 8'h0c);
		ev(1'b1, 1'b0, 16'h0, 16'h0);
		rc(8'h8e, 8'h08);
		ev(1'b0, 1'b1, 16'h0, 16'h0);
		h.wr(8'h8e, 8'h00);
		rc(8'h8e, 8'h0c);
		chk({7'h0, irq_n}, 8'h00);
		fork
			h.wr(8'h8e, 8'h0f);
			ev(1'b1, 1'b0, 16'h0, 16'h0);
		join
		rc(8'h8e, 8'h08);
		h.wr(8'h8e, 8'h0f);
		rc(8'h8e, 8'h00);
		chk({7'h0, irq_n}, 8'h01);
		h.wr(8'h89, 8'h02);
		ev(1'b1, 1'b1, 16'h0, 16'h0);
		rc(8'h8e, 8'h00);
		$display("test events done");
		h.wr(8'h8a, 8'h01);
		h.wr(8'h8b, 8'h00);
		h.wr(8'h8c, 8'h80);
		h.wr(8'h8d, 8'h00);
		for (int k = 0; k < 8; k++) begin
			v = 16'($urandom);
			v = k == 6 ? 16'h8000 : k == 7 ? 16'h0100 :
				k[0] ? (v | 16'h8001) : {8'h00, v[7:0]};
			ev(1'b1, 1'b0, v, 16'h4000);
			rc(8'h8e, lim(v));
			h.wr(8'h8e, 8'h0f);
			ev(1'b1, 1'b0, 16'h4000, 16'h4000);
		end
		h.wr(8'h89, 8'h03);
		ev(1'b1, 1'b0, 16'hffff, 16'h4000);
		rc(8'h8e, 8'h00);
		ev(1'b0, 1'b1, 16'h4000, 16'hffff);
		rc(8'h8e, 8'h01);
		h.wr(8'h8e, 8'h0f);
		h.wr(8'h89, 8'h22);
		ev(1'b1, 1'b0, 16'h0000, 16'h0);
		rc(8'h8e, 8'h00);
		ev(1'b1, 1'b0, 16'h0000, 16'h0);
		rc(8'h8e, 8'h02);
		$display("test limits done");
		close_out();
	end
endmodule : tb_sensor_irq_status_and_modulator_timing
